// ==== verilog/cfm_clock_fault_monitor.v ====
// clock fault monitor: absence, drift, unlock, crystal detection with flags
//
// How it works
// - live bit high only while fault present
// - sticky flag holds fault until software clears
// - alarm pin: one flag or ORed set
// - fixed pins carry clock defect summaries
// - selected flags drive active-low interrupt
// - monitors use predivided input clocks
// - four absence detectors, programmable loss/recovery counts
// - loss asserts at loss edge count
// - recovery when missing edges below recovery count
// - clear after recovery holds qualify time
// - drift against selectable golden clock
// - fine drift 2 ppm step, 2-510
// - drift set/clear hysteresis
// - coarse drift 100 ppm step, 100-3100
// - drift optionally ORed into switch request
// - per-PLL reference versus feedback unlock detect
// - unlock set/clear threshold choice tables
// - unlock held through programmable deassert delay
// - crystal alarm when pin or internal absent
`timescale 1ns/100ps
`default_nettype none
`include "cfm_regs.vh"
module cfm_clock_fault_monitor #(
  parameter QUAL_US_0 = `CFM_QUAL_US_0,
  parameter QUAL_US_1 = `CFM_QUAL_US_1,
  parameter QUAL_US_2 = `CFM_QUAL_US_2,
  parameter QUAL_US_3 = `CFM_QUAL_US_3,
  parameter MISS_TICKS = 16
) (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // predivided input clocks sampled as levels
  input wire [3:0] input_predivider,
  // crystal reference pin and internal crystal clock
  input wire crystal_ref_pin,
  input wire xo_int_clk,
  // per-PLL measured frequency error in units of 0.2 ppm
  input wire [79:0] pll_err_ppm5,
  // per-input drift measurement against golden, ppm magnitude
  input wire [43:0] drift_ppm,
  // alarm outputs
  output reg [1:0] programmable_alarm_pin,
  output reg [3:0] input_absence_alarm,
  output reg [3:0] frequency_drift_alarm,
  output reg [3:0] loop_unlock_alarm,
  output reg crystal_ref_missing,
  output reg [3:0] switch_request,
  output reg [2:0] golden_sel,
  output reg interrupt_out_n
);

  // ====================================================
  // functions
  function [4:0] sel_to_idx;
    input [4:0] s;
    begin
      sel_to_idx = (s > 5'h10) ? 5'h10 : s;
    end
  endfunction

  function [15:0] lock_set_tab;
    input [3:0] s;
    begin
      case (s)
        4'h0: lock_set_tab = 16'h0001;
        4'h1: lock_set_tab = 16'h0002;
        4'h2: lock_set_tab = 16'h000A;
        4'h3: lock_set_tab = 16'h0014;
        4'h4: lock_set_tab = 16'h0064;
        4'h5: lock_set_tab = 16'h00C8;
        4'h6: lock_set_tab = 16'h03E8;
        4'h7: lock_set_tab = 16'h07D0;
        4'h8: lock_set_tab = 16'h2710;
        default: lock_set_tab = 16'h4E20;
      endcase
    end
  endfunction

  function [15:0] lock_clr_tab;
    input [1:0] s;
    begin
      case (s)
        2'h0: lock_clr_tab = 16'h0001;
        2'h1: lock_clr_tab = 16'h0002;
        2'h2: lock_clr_tab = 16'h000A;
        default: lock_clr_tab = 16'h03E8;
      endcase
    end
  endfunction

  // ====================================================
  // configuration registers
  reg [31:0] irq_sel_r;
  reg [31:0] pin0_sel_r;
  reg [31:0] pin1_sel_r;
  reg [31:0] abs_cfg_r;
  reg [31:0] drift_cfg_r;
  reg [31:0] lock_cfg_r;
  reg [31:0] sw_cfg_r;
  reg [31:0] lock_dly_r;
  reg [`CFM_NFAULT-1:0] flag_r;
  wire [`CFM_NFAULT-1:0] live;
  wire wr_flag;
  assign wr_flag = reg_wr && (reg_addr == `CFM_ADDR_FLAG);

  always @(posedge core_clk) begin
    if (!rst_b) begin
      irq_sel_r <= 32'h00000000;
      pin0_sel_r <= 32'h00000000;
      pin1_sel_r <= 32'h00000000;
      abs_cfg_r <= `CFM_RST_ABS_CFG;
      drift_cfg_r <= `CFM_RST_DRIFT_CFG;
      lock_cfg_r <= `CFM_RST_LOCK_CFG;
      sw_cfg_r <= 32'h00000000;
      golden_sel <= 3'h4;
      lock_dly_r <= `CFM_RST_LOCK_DLY;
    end else if (reg_wr) begin
      case (reg_addr)
        `CFM_ADDR_IRQ_SEL: irq_sel_r <= reg_wdata;
        `CFM_ADDR_PIN0_SEL: pin0_sel_r <= reg_wdata;
        `CFM_ADDR_PIN1_SEL: pin1_sel_r <= reg_wdata;
        `CFM_ADDR_ABS_CFG: abs_cfg_r <= reg_wdata;
        `CFM_ADDR_DRIFT_CFG: drift_cfg_r <= reg_wdata;
        `CFM_ADDR_LOCK_CFG: lock_cfg_r <= reg_wdata;
        `CFM_ADDR_SW_CFG: sw_cfg_r <= reg_wdata;
        `CFM_ADDR_GOLD: golden_sel <= (reg_wdata[2:0] > 3'h4) ? 3'h4 : reg_wdata[2:0];
        `CFM_ADDR_LOCK_DLY: lock_dly_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // sticky flags, set wins over clear
  always @(posedge core_clk) begin
    if (!rst_b)
      flag_r <= {`CFM_NFAULT{1'b0}};
    else
      flag_r <= (flag_r & ~(wr_flag ? reg_wdata[`CFM_NFAULT-1:0] : {`CFM_NFAULT{1'b0}}))
                | live;
  end

  // read port
  always @(posedge core_clk) begin
    if (!rst_b)
      reg_rdata <= 32'h00000000;
    else if (reg_rd) begin
      case (reg_addr)
        `CFM_ADDR_LIVE: reg_rdata <= {15'h0000, live};
        `CFM_ADDR_FLAG: reg_rdata <= {15'h0000, flag_r};
        `CFM_ADDR_IRQ_SEL: reg_rdata <= irq_sel_r;
        `CFM_ADDR_PIN0_SEL: reg_rdata <= pin0_sel_r;
        `CFM_ADDR_PIN1_SEL: reg_rdata <= pin1_sel_r;
        `CFM_ADDR_ABS_CFG: reg_rdata <= abs_cfg_r;
        `CFM_ADDR_DRIFT_CFG: reg_rdata <= drift_cfg_r;
        `CFM_ADDR_LOCK_CFG: reg_rdata <= lock_cfg_r;
        `CFM_ADDR_SW_CFG: reg_rdata <= sw_cfg_r;
        `CFM_ADDR_GOLD: reg_rdata <= {29'h00000000, golden_sel};
        `CFM_ADDR_LOCK_DLY: reg_rdata <= lock_dly_r;
        default: reg_rdata <= 32'h00000000;
      endcase
    end else
      reg_rdata <= 32'h00000000;
  end

  // ====================================================
  // input synchronisers and absence detectors
  localparam integer Q0 = QUAL_US_0 * `CFM_CLK_MHZ;
  localparam integer Q1 = QUAL_US_1 * `CFM_CLK_MHZ;
  localparam integer Q2 = QUAL_US_2 * `CFM_CLK_MHZ;
  localparam integer Q3 = QUAL_US_3 * `CFM_CLK_MHZ;
  reg [26:0] qual_lim;
  always @* begin
    case (abs_cfg_r[17:16])
      2'h0: qual_lim = Q0[26:0];
      2'h1: qual_lim = Q1[26:0];
      2'h2: qual_lim = Q2[26:0];
      default: qual_lim = Q3[26:0];
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_abs
      reg s1_r, s2_r, s3_r, prev_r;
      reg [7:0] tick_r;
      reg [7:0] miss_r;
      reg [26:0] qcnt_r;
      reg lost_r;
      wire edge_seen;
      // three-stage sync of the predivided clock
      always @(posedge core_clk) begin
        if (!rst_b) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          prev_r <= 1'b0;
        end else begin
          s1_r <= input_predivider[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            prev_r <= s3_r;
        end
      end
      assign edge_seen = (s2_r == s3_r) && (s3_r != prev_r);
      // count expected edge slots with no edge
      always @(posedge core_clk) begin
        if (!rst_b) begin
          tick_r <= 8'h00;
          miss_r <= 8'h00;
          qcnt_r <= 27'h0000000;
          lost_r <= 1'b0;
        end else begin
          if (edge_seen) begin
            tick_r <= 8'h00;
            miss_r <= 8'h00;
          end else if (tick_r == MISS_TICKS[7:0] - 8'h01) begin
            tick_r <= 8'h00;
            if (miss_r != 8'hFF)
              miss_r <= miss_r + 8'h01;
          end else
            tick_r <= tick_r + 8'h01;
          if (!lost_r) begin
            qcnt_r <= 27'h0000000;
            if (miss_r >= abs_cfg_r[7:0])
              lost_r <= 1'b1;
          end else if (miss_r >= abs_cfg_r[15:8])
            qcnt_r <= 27'h0000000;
          else if (qcnt_r >= qual_lim - 27'h0000001) begin
            lost_r <= 1'b0;
            qcnt_r <= 27'h0000000;
          end else
            qcnt_r <= qcnt_r + 27'h0000001;
        end
      end
      assign live[`CFM_F_ABS+gi] = lost_r;
    end
  endgenerate

  // ====================================================
  // drift monitors with hysteresis
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_drift
      reg fine_r, coarse_r;
      wire [10:0] d;
      wire is_gold;
      assign d = drift_ppm[gi*11 +: 11];
      assign is_gold = (golden_sel == gi);
      always @(posedge core_clk) begin
        if (!rst_b) begin
          fine_r <= 1'b0;
          coarse_r <= 1'b0;
        end else if (is_gold) begin
          fine_r <= 1'b0;
          coarse_r <= 1'b0;
        end else begin
          // fine thresholds in 2 ppm steps
          if (!fine_r && d >= {2'b00, drift_cfg_r[7:0], 1'b0})
            fine_r <= 1'b1;
          else if (fine_r && d <= {2'b00, drift_cfg_r[15:8], 1'b0})
            fine_r <= 1'b0;
          // coarse thresholds in 100 ppm steps
          if (!coarse_r && {1'b0, d} >= drift_cfg_r[20:16] * 12'd100)
            coarse_r <= 1'b1;
          else if (coarse_r && {1'b0, d} <= drift_cfg_r[28:24] * 12'd100)
            coarse_r <= 1'b0;
        end
      end
      assign live[`CFM_F_FINE+gi] = fine_r;
      assign live[`CFM_F_COARSE+gi] = coarse_r;
    end
  endgenerate

  // ====================================================
  // loop unlock detectors with deassert delay
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lock
      reg unl_r;
      reg [31:0] dly_r;
      wire [15:0] e;
      assign e = pll_err_ppm5[gi*20 +: 16];
      always @(posedge core_clk) begin
        if (!rst_b) begin
          unl_r <= 1'b0;
          dly_r <= 32'h00000000;
        end else if (e >= lock_set_tab(lock_cfg_r[3:0])) begin
          unl_r <= 1'b1;
          dly_r <= 32'h00000000;
        end else if (unl_r) begin
          if (e > lock_clr_tab(lock_cfg_r[5:4]))
            dly_r <= 32'h00000000;
          else if (dly_r >= lock_dly_r)
            unl_r <= 1'b0;
          else
            dly_r <= dly_r + 32'h00000001;
        end
      end
      assign live[`CFM_F_LOCK+gi] = unl_r;
    end
  endgenerate

  // ====================================================
  // crystal reference presence
  reg [2:0] xp_r, xi_r;
  reg xp_prev_r, xi_prev_r;
  reg [7:0] xp_cnt_r, xi_cnt_r;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      xp_r <= 3'h0;
      xi_r <= 3'h0;
      xp_prev_r <= 1'b0;
      xi_prev_r <= 1'b0;
      xp_cnt_r <= 8'h00;
      xi_cnt_r <= 8'h00;
    end else begin
      xp_r <= {xp_r[1:0], crystal_ref_pin};
      xi_r <= {xi_r[1:0], xo_int_clk};
      if (xp_r[1] == xp_r[2]) xp_prev_r <= xp_r[2];
      if (xi_r[1] == xi_r[2]) xi_prev_r <= xi_r[2];
      if (xp_r[1] == xp_r[2] && xp_r[2] != xp_prev_r)
        xp_cnt_r <= 8'h00;
      else if (xp_cnt_r != 8'hFF)
        xp_cnt_r <= xp_cnt_r + 8'h01;
      if (xi_r[1] == xi_r[2] && xi_r[2] != xi_prev_r)
        xi_cnt_r <= 8'h00;
      else if (xi_cnt_r != 8'hFF)
        xi_cnt_r <= xi_cnt_r + 8'h01;
    end
  end
  assign live[`CFM_F_XO] = (xp_cnt_r >= MISS_TICKS[7:0]) || (xi_cnt_r >= MISS_TICKS[7:0]);

  // ====================================================
  // outputs
  wire [`CFM_NFAULT-1:0] f0, f1;
  assign f0 = flag_r;
  assign f1 = flag_r;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      programmable_alarm_pin <= 2'b00;
      input_absence_alarm <= 4'h0;
      frequency_drift_alarm <= 4'h0;
      loop_unlock_alarm <= 4'h0;
      crystal_ref_missing <= 1'b0;
      switch_request <= 4'h0;
      interrupt_out_n <= 1'b1;
    end else begin
      programmable_alarm_pin[0] <= pin0_sel_r[`CFM_PIN_MODE_BIT] ?
        |(f0 & pin0_sel_r[`CFM_NFAULT-1:0]) : f0[sel_to_idx(pin0_sel_r[4:0])];
      programmable_alarm_pin[1] <= pin1_sel_r[`CFM_PIN_MODE_BIT] ?
        |(f1 & pin1_sel_r[`CFM_NFAULT-1:0]) : f1[sel_to_idx(pin1_sel_r[4:0])];
      input_absence_alarm <= live[3:0];
      frequency_drift_alarm <= live[7:4] | live[11:8];
      loop_unlock_alarm <= live[15:12];
      crystal_ref_missing <= live[16];
      switch_request <= live[3:0] | (sw_cfg_r[0] ? live[7:4] : 4'h0)
                        | (sw_cfg_r[1] ? live[11:8] : 4'h0);
      interrupt_out_n <= ~|(flag_r & irq_sel_r[`CFM_NFAULT-1:0]);
    end
  end

endmodule // cfm_clock_fault_monitor
`default_nettype wire

// ==== verilog/cfm_regs.vh ====
// register offsets, fields and timing constants of the clock fault monitor
`ifndef CFM_REGS_VH
`define CFM_REGS_VH
`define CFM_ADDR_LIVE 8'h00
`define CFM_ADDR_FLAG 8'h04
`define CFM_ADDR_IRQ_SEL 8'h08
`define CFM_ADDR_PIN0_SEL 8'h0C
`define CFM_ADDR_PIN1_SEL 8'h10
`define CFM_ADDR_ABS_CFG 8'h14
`define CFM_ADDR_DRIFT_CFG 8'h18
`define CFM_ADDR_LOCK_CFG 8'h1C
`define CFM_ADDR_SW_CFG 8'h20
`define CFM_ADDR_GOLD 8'h24
`define CFM_ADDR_LOCK_DLY 8'h28
// fault vector layout
`define CFM_F_ABS 0
`define CFM_F_FINE 4
`define CFM_F_COARSE 8
`define CFM_F_LOCK 12
`define CFM_F_XO 16
`define CFM_NFAULT 17
// pin select register fields
`define CFM_PIN_MODE_BIT 31
// reset values
`define CFM_RST_ABS_CFG 32'h00000404
`define CFM_RST_DRIFT_CFG 32'h04020A05
`define CFM_RST_LOCK_CFG 32'h00000024
`define CFM_RST_LOCK_DLY 32'h000003E8
// qualify times in microseconds
`define CFM_QUAL_US_0 2000
`define CFM_QUAL_US_1 100000
`define CFM_QUAL_US_2 200000
`define CFM_QUAL_US_3 1000000
`define CFM_CLK_MHZ 100
// drift steps in ppm
`define CFM_FINE_STEP_PPM 2
`define CFM_COARSE_STEP_PPM 100
`endif

// ==== bench/cfm_monitor_asserts.sv ====
// port-level assertion checker for the clock fault monitor
`timescale 1ns/100ps
`default_nettype none
module cfm_monitor_asserts #(
  parameter QUAL_US_0 = 1,
  parameter MISS_TICKS = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // monitored sources
  input wire logic [3:0] input_predivider,
  input wire logic crystal_ref_pin,
  input wire logic xo_int_clk,
  input wire logic [79:0] pll_err_ppm5,
  // alarms
  input wire logic [3:0] input_absence_alarm,
  input wire logic [3:0] frequency_drift_alarm,
  input wire logic [3:0] loop_unlock_alarm,
  input wire logic crystal_ref_missing,
  input wire logic [3:0] switch_request,
  input wire logic [2:0] golden_sel
);
  // ==========
  // gap, run and settle counters
  int gap0_r, run0_r, gapx_r, low_r;
  logic in0_r;
  logic [1:0] xo_r;
  always @(posedge core_clk) begin
    in0_r <= input_predivider[0];
    xo_r <= {crystal_ref_pin, xo_int_clk};
    if (!rst_b || in0_r != input_predivider[0]) gap0_r <= 0;
    else gap0_r <= gap0_r + 1;
    if (!rst_b || gap0_r >= MISS_TICKS) run0_r <= 0;
    else run0_r <= run0_r + 1;
    if (!rst_b || xo_r != {crystal_ref_pin, xo_int_clk}) gapx_r <= 0;
    else gapx_r <= gapx_r + 1;
    if (!rst_b || pll_err_ppm5[15:0] >= 16'h000A) low_r <= 0;
    else low_r <= low_r + 1;
  end
  // ==========
  // assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("idle read data");
  a_status_upper:
    assert property ($past(reg_rd) && $past(reg_addr) < 8'h08 |-> reg_rdata[31:17] == 15'h0)
      else $error("status upper bits");
  a_abs_loss:
    assert property (gap0_r >= 4 * MISS_TICKS + 8 |-> input_absence_alarm[0])
      else $error("absence not raised");
  a_abs_qualify:
    assert property ($fell(input_absence_alarm[0]) |-> run0_r >= QUAL_US_0 * 100)
      else $error("absence cleared early");
  a_xo_missing:
    assert property (gapx_r >= MISS_TICKS + 8 |-> crystal_ref_missing)
      else $error("crystal loss not raised");
  a_unlock_set:
    assert property ((pll_err_ppm5[15:0] > 16'h0064) [*3] |=> loop_unlock_alarm[0])
      else $error("unlock not raised");
  a_unlock_hold:
    assert property ($fell(loop_unlock_alarm[0]) |-> low_r >= 1000)
      else $error("unlock cleared early");
  a_gold_zero:
    assert property (golden_sel < 3'h4 && $stable(golden_sel) && $past(golden_sel, 2) == golden_sel
      |-> !frequency_drift_alarm[golden_sel[1:0]]) else $error("golden drift set");
  a_switch_cause:
    assert property ((switch_request & ~(input_absence_alarm | frequency_drift_alarm)) == 4'h0)
      else $error("switch without cause");
  c_abs: cover property ($fell(input_absence_alarm[0]));
  c_unlock: cover property ($fell(loop_unlock_alarm[0]));
  c_xo: cover property ($rose(crystal_ref_missing));
endmodule // cfm_monitor_asserts
bind cfm_clock_fault_monitor cfm_monitor_asserts #(
  .QUAL_US_0(QUAL_US_0),
  .MISS_TICKS(MISS_TICKS)
) u_chk (.*);
`default_nettype wire

// ==== bench/cfm_clk_src.sv ====
// model of the predivided input clocks and crystal sources
`timescale 1ns/100ps
`default_nettype none
module cfm_clk_src (
  // clock
  input wire logic core_clk,
  // run controls
  input wire logic [3:0] run,
  input wire logic xo_run,
  // source levels
  output logic [3:0] input_predivider,
  output logic crystal_ref_pin,
  output logic xo_int_clk
);
  // ==========
  // sources toggle while running, frozen when stopped
  logic [7:0] cnt_r;
  initial begin
    cnt_r = 8'h00;
    input_predivider = 4'h0;
    crystal_ref_pin = 1'b0;
    xo_int_clk = 1'b0;
  end
  always @(posedge core_clk) begin
    cnt_r <= cnt_r + 8'h01;
    for (int i = 0; i < 4; i++) begin
      if (run[i] && cnt_r[1:0] == i[1:0]) begin
        input_predivider[i] <= ~input_predivider[i];
      end
    end
    if (xo_run) begin
      crystal_ref_pin <= cnt_r[2];
      xo_int_clk <= cnt_r[1];
    end
  end
endmodule // cfm_clk_src
`default_nettype wire

// ==== bench/cfm_clock_fault_monitor_tb.sv ====
// self-checking bench for the clock fault monitor
`timescale 1ns/100ps
`default_nettype none
`include "cfm_regs.vh"
module cfm_clock_fault_monitor_tb;
  // ==========
  // signals
  logic core_clk, rst_b, reg_wr, reg_rd, rd_d, xo_run;
  logic crystal_ref_pin, xo_int_clk, crystal_ref_missing, interrupt_out_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] run, input_predivider, input_absence_alarm, frequency_drift_alarm;
  logic [3:0] loop_unlock_alarm, switch_request;
  logic [79:0] pll_err_ppm5;
  logic [43:0] drift_ppm;
  logic [1:0] programmable_alarm_pin;
  logic [2:0] golden_sel;
  logic [31:0] exp_q[$];
  logic [10:0] dv [3] = '{11'h258, 11'h030, 11'h014};
  logic [31:0] lv [3] = '{32'h440, 32'h40, 32'h0};
  int num_errors, n_compared, cyc, seed;
  cfm_clock_fault_monitor #(.QUAL_US_0(1), .QUAL_US_1(1), .QUAL_US_2(1), .QUAL_US_3(1)) dut (.*);
  cfm_clk_src u_src (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    w(1);
    reg_wr <= 1'b0;
    w(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    w(1);
    reg_rd <= 1'b0;
    w(1);
  endtask
  task automatic results;
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========
  // read monitor and timeout
  always @(posedge core_clk) begin
    cyc++;
    if (rd_d) chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
    if (cyc == 6000) begin
      num_errors++;
      results;
    end
  end
  // ==========
  // main sequence
  initial begin
    seed = 32'h2BEC76B6;
    {rst_b, reg_wr, reg_rd, rd_d, reg_addr, reg_wdata} = '0;
    {pll_err_ppm5, drift_ppm, cyc, num_errors, n_compared} = '0;
    run = 4'hF;
    xo_run = 1'b1;
    w(5);
    rst_b <= 1'b1;
    w(1);
    rd(`CFM_ADDR_ABS_CFG, `CFM_RST_ABS_CFG);
    rd(`CFM_ADDR_DRIFT_CFG, `CFM_RST_DRIFT_CFG);
    rd(`CFM_ADDR_LOCK_CFG, `CFM_RST_LOCK_CFG);
    rd(`CFM_ADDR_LOCK_DLY, `CFM_RST_LOCK_DLY);
    rd(`CFM_ADDR_GOLD, 32'h4);
    rd(8'hFC, 32'h0);
    rd(`CFM_ADDR_LIVE, 32'h0);
    chk({golden_sel, interrupt_out_n}, 4'h9);
    run <= 4'hE;
    w(120);
    rd(`CFM_ADDR_LIVE, 32'h1);
    rd(`CFM_ADDR_FLAG, 32'h1);
    chk({input_absence_alarm, switch_request}, 8'h11);
    wr(`CFM_ADDR_IRQ_SEL, 32'h2);
    wr(`CFM_ADDR_PIN0_SEL, 32'h0);
    wr(`CFM_ADDR_PIN1_SEL, 32'h80010001);
    w(3);
    chk({interrupt_out_n, programmable_alarm_pin}, 3'h7);
    wr(`CFM_ADDR_IRQ_SEL, 32'h1);
    w(3);
    chk(interrupt_out_n, 1'b0);
    run <= 4'hF;
    w(40);
    rd(`CFM_ADDR_LIVE, 32'h1);
    w(300);
    rd(`CFM_ADDR_LIVE, 32'h0);
    wr(`CFM_ADDR_FLAG, 32'h0);
    rd(`CFM_ADDR_FLAG, 32'h1);
    wr(`CFM_ADDR_FLAG, 32'h1);
    rd(`CFM_ADDR_FLAG, 32'h0);
    w(3);
    chk({interrupt_out_n, programmable_alarm_pin}, 3'h4);
    wr(`CFM_ADDR_GOLD, 32'h0);
    wr(`CFM_ADDR_DRIFT_CFG, 32'h03051020);
    wr(`CFM_ADDR_SW_CFG, 32'h1);
    drift_ppm <= {11'($unsigned($random(seed)) % 32'h20), 11'h064, 11'h000, 11'h258};
    w(10);
    rd(`CFM_ADDR_LIVE, 32'h40);
    chk({frequency_drift_alarm, switch_request, 1'b0, golden_sel}, 12'h440);
    wr(`CFM_ADDR_SW_CFG, 32'h2);
    for (int i = 0; i < 3; i++) begin
      drift_ppm[32:22] <= dv[i];
      w(10);
      rd(`CFM_ADDR_LIVE, lv[i]);
      chk(switch_request, {1'b0, lv[i][10], 2'b00});
    end
    pll_err_ppm5 <= {4'h0, 16'($unsigned($random(seed)) % 32'hA), 40'h0, 20'h00200};
    w(10);
    rd(`CFM_ADDR_LIVE, 32'h1000);
    chk(loop_unlock_alarm, 4'h1);
    pll_err_ppm5[15:0] <= 16'h0005;
    w(900);
    rd(`CFM_ADDR_LIVE, 32'h1000);
    w(200);
    rd(`CFM_ADDR_LIVE, 32'h0);
    xo_run <= 1'b0;
    w(40);
    rd(`CFM_ADDR_LIVE, 32'h10000);
    chk(crystal_ref_missing, 1'b1);
    xo_run <= 1'b1;
    w(40);
    rd(`CFM_ADDR_LIVE, 32'h0);
    w(1);
    chk(exp_q.size(), 32'h0);
    results;
  end
endmodule // cfm_clock_fault_monitor_tb
`default_nettype wire
